// *** dv/nirq_core_model.sv ***
module nirq_core_model
(
    input  logic        core_clk,
    input  logic        sys_rst,
    input  logic        irq_req,
    input  logic [15:0] irq_vector,
    input  logic [1:0]  cur_prio,
    input  logic        return_from_irq,
    input  logic        pop_flags_instr,
    input  logic        ack_slow,
    output logic        irq_ack = 1'b0,
    output logic [1:0]  stacked_prio = 2'b00,
    output logic [15:0] taken_vec = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] stk [$];
    int         cnt = 0;
    ////////////////////////////////////////
    // A request may still read high just after an acknowledge, so the
    // model rests a few cycles before it may answer again.
    always @(posedge core_clk)
    begin
        irq_ack <= 1'b0;
        if (sys_rst)
            stk.delete();
        else if ((return_from_irq || pop_flags_instr) && stk.size() > 0)
            void'(stk.pop_back());
        if (cnt < 0)
            cnt = cnt + 1;
        else if (irq_req && !sys_rst)
        begin
            cnt = cnt + 1;
            if (cnt > (ack_slow ? 3 : 0))
            begin
                irq_ack <= 1'b1;
                taken_vec <= irq_vector;
                stk.push_back(cur_prio);
                cnt = -3;
            end
        end
        stacked_prio <= (stk.size() > 0) ? stk[$] : 2'b00;
    end
endmodule // nirq_core_model

// *** dv/nirq_ctrl_properties.sv ***
module nirq_ctrl_properties
(
    input logic        core_clk,
    input logic        sys_rst,
    input logic        trap_instr,
    input logic        reset_vector_fetch,
    input logic        halt_instr,
    input logic        wait_for_irq_instr,
    input logic        irq_unmask_instr,
    input logic        irq_mask_instr,
    input logic        return_from_irq,
    input logic        pop_flags_instr,
    input logic [1:0]  stacked_prio,
    input logic        irq_ack,
    input logic [1:0]  cur_prio,
    input logic        branch_if_masked,
    input logic        branch_if_unmasked,
    input logic        irq_req,
    input logic [15:0] irq_vector
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    logic hi;
    logic lo;
    logic rs;
    assign hi = irq_mask_instr | trap_instr | reset_vector_fetch;
    assign lo = halt_instr | wait_for_irq_instr | irq_unmask_instr;
    assign rs = return_from_irq | pop_flags_instr;
    ////////////////////////////////////////
    a_mask_sets_three: assert property (hi |=> cur_prio == 2'b11)
        else $error("level 3 not loaded");
    a_unmask_sets_zero: assert property (
        lo && !hi && !rs && !irq_ack |=> cur_prio == 2'b10)
        else $error("level 0 not loaded");
    a_pop_restores_level: assert property (
        rs && !hi && !lo && !irq_ack |=> cur_prio == $past(stacked_prio))
        else $error("stacked level not restored");
    a_branch_tracks_level: assert property (
        branch_if_masked == (cur_prio == 2'b11) && branch_if_unmasked == !branch_if_masked)
        else $error("branch flags wrong");
    a_level_holds_idle: assert property (
        !(hi || lo || rs || irq_ack) |=> $stable(cur_prio))
        else $error("level changed without cause");
    a_pin_service_three: assert property (
        irq_ack && irq_vector == 16'hFFFA && !(lo || rs) |=> cur_prio == 2'b11)
        else $error("pin service not level 3");
    a_vector_in_map: assert property (
        irq_req |-> !irq_vector[0] && irq_vector >= 16'hFFE0 && irq_vector <= 16'hFFFA)
        else $error("vector outside map");
    a_served_not_zero: assert property (
        irq_ack && irq_vector != 16'hFFFA && !(hi || lo || rs) |=> cur_prio != 2'b10)
        else $error("service loaded level 0");
endmodule // nirq_ctrl_properties

bind nirq_ctrl nirq_ctrl_properties chk_u (.*);

// *** dv/test_nested_irq_priority_and_ext_sense.sv ***
module test_nested_irq_priority_and_ext_sense;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        top_pin = 1'b1;
    logic [3:0]  port_a_pins = 4'hF;
    logic [7:0]  port_b_pins = 8'hFF;
    logic        halted = 1'b0;
    logic        ack_slow = 1'b0;
    logic [7:0]  ops = 8'h00;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq_ack, irq_req, wake_req;
    wire         branch_if_masked, branch_if_unmasked;
    wire  [1:0]  cur_prio, stacked_prio;
    wire  [15:0] irq_vector, taken_vec;
    logic [7:0]  pr [0:4] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    logic [7:0]  rd;
    logic [1:0]  lv = 2'b11;
    logic        wk;
    int          codes [9] = '{5, 4, 7, 2, 0, 3, 1, 6, 5};
    logic [1:0]  exps [9] = '{3, 2, 0, 2, 3, 2, 3, 0, 3};
    int          num_errors = 0;
    int          n_checks = 0;
    nirq_ctrl dut_u (.*, .periph_irq(9'h000), .spi_slave_mode(1'b0), .pwm_ext_clk(1'b0),
        .active_halt(1'b0), .port_f_pins(3'h7), .trap_instr(ops[0]),
        .reset_vector_fetch(ops[1]), .halt_instr(ops[2]), .wait_for_irq_instr(ops[3]),
        .irq_unmask_instr(ops[4]), .irq_mask_instr(ops[5]), .return_from_irq(ops[6]),
        .pop_flags_instr(ops[7]));
    nirq_core_model core_u (.*, .return_from_irq(ops[6]), .pop_flags_instr(ops[7]));
    always #5 core_clk = ~core_clk;
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rd = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Level 0 codes never land in a pair; the sense lock follows the level.
    function automatic logic [7:0] upd(int i, logic [7:0] o, logic [7:0] w);
        upd = (i == 4) ? o : w;
        for (int k = 0; k < 8 && i < 4; k += 2)
            if (w[k+:2] == 2'b10)
                upd[k+:2] = o[k+:2];
        if (i == 3)
            upd[7:4] = 4'hF;
        if (i == 4 && lv == 2'b11)
            upd[7:2] = w[7:2];
        if (i == 4 && !o[0])
            upd[1] = w[1];
        if (i == 4)
            upd[0] = w[0];
    endfunction
    task automatic wreg(input int i, input logic [7:0] v);
        apb(1'b1, 12'(i * 4), v);
        pr[i] = upd(i, pr[i], v);
        apb(1'b0, 12'(i * 4), 8'h00);
        chk(rd, pr[i]);
    endtask
    task automatic op(input int b, input logic [1:0] e);
        @(posedge core_clk);
        ops[b] <= 1'b1;
        @(posedge core_clk);
        ops <= 8'h00;
        #1;
        lv = e;
        chk(cur_prio, e);
        chk(branch_if_unmasked, e != 2'b11);
    endtask
    task automatic get_irq;
        wk = 1'b0;
        for (int k = 0; k < 100 && irq_ack !== 1'b1; k++)
        begin
            @(posedge core_clk);
            wk = wk | (wake_req === 1'b1);
        end
        chk(irq_ack, 1'b1);
        #1;
    endtask
    ////////////////////////////////////////
    initial
    begin
        rd = 8'($urandom(32'h6C58));
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, (i == 5) ? 12'h018 : 12'(i * 4), 8'h00);
            chk(rd, (i == 5) ? 8'h00 : pr[i]);
        end
        wreg(0, 8'hCF);
        wreg(0, 8'h64);
        chk(rd, 8'h44);
        wreg(3, 8'h00);
        for (int k = 0; k < 8; k++)
            wreg($urandom % 4, 8'($urandom));
        foreach (codes[k])
            op(codes[k], exps[k]);
        wreg(4, 8'hFE);
        op(4, 2'b10);
        wreg(4, 8'h00);
        op(5, 2'b11);
        wreg(4, 8'h10);
        wreg(0, 8'hDD);
        op(4, 2'b10);
        @(posedge core_clk);
        port_a_pins <= 4'h0;
        get_irq;
        chk(taken_vec, 16'hFFF6);
        chk(cur_prio, 2'b01);
        lv = 2'b01;
        wreg(4, 8'h11);
        halted <= 1'b1;
        ack_slow <= 1'b1;
        top_pin <= 1'b0;
        get_irq;
        chk(wk, 1'b1);
        chk(taken_vec, 16'hFFFA);
        chk(cur_prio, 2'b11);
        halted <= 1'b0;
        op(6, 2'b01);
        op(6, 2'b10);
        // mask before every sense change below.
        op(5, 2'b11);
        wreg(4, 8'h1D);
        @(posedge core_clk);
        port_a_pins <= 4'h1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, 12'h014, 8'h00);
        chk(rd, 8'h04);
        wreg(4, 8'h15);
        apb(1'b0, 12'h014, 8'h00);
        chk(rd, 8'h00);
        wreg(4, 8'h35);
        @(posedge core_clk);
        port_a_pins <= 4'h0;
        repeat (3) @(posedge core_clk);
        apb(1'b0, 12'h014, 8'h00);
        chk(rd, 8'h10);
        finish_test;
    end
    initial
    begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        finish_test;
    end
endmodule // test_nested_irq_priority_and_ext_sense

// *** logic/nirq_ctrl.v ***
// Implementation choices: the register addresses and the APB interface to the registers.
`include "nirq_defines.vh"

module nirq_ctrl
(
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        top_pin,
    input  wire [3:0]  port_a_pins,
    input  wire [2:0]  port_f_pins,
    input  wire [7:0]  port_b_pins,
    input  wire [13:5] periph_irq,
    input  wire        spi_slave_mode,
    input  wire        pwm_ext_clk,
    input  wire        halted,
    input  wire        active_halt,
    input  wire        trap_instr,
    input  wire        reset_vector_fetch,
    input  wire        halt_instr,
    input  wire        wait_for_irq_instr,
    input  wire        irq_unmask_instr,
    input  wire        irq_mask_instr,
    input  wire        return_from_irq,
    input  wire        pop_flags_instr,
    input  wire [1:0]  stacked_prio,
    input  wire        irq_ack,
    output reg  [1:0]  cur_prio,
    output wire        branch_if_masked,
    output wire        branch_if_unmasked,
    output reg         irq_req,
    output reg  [15:0] irq_vector,
    output reg         wake_req
);

    ////////////////////////////////////////////////////////////////////////////
    reg  [7:0]  prio_reg [0:3];
    reg  [7:0]  ext_sense_ctrl;
    reg  [13:0] pending;
    reg  [13:0] in_service;
    reg  [3:0]  line_s1;
    reg  [3:0]  line_s2;
    reg  [3:0]  line_prev;
    reg  [1:0]  top_s;
    reg         top_prev;
    reg  [3:0]  line_hit;
    reg  [3:0]  next_src;
    reg         next_found;
    reg  [2:0]  next_lvl;
    reg  [13:0] wake_ok;
    integer     i;
    integer     j;

    wire        bus_wr = psel & penable & pwrite;
    wire        at_lvl3 = (cur_prio == `NIRQ_LVL3);
    wire [1:0]  sense_sel_port_b   = ext_sense_ctrl[7:6];
    wire        polarity_port_b    = ext_sense_ctrl[5];
    wire [1:0]  sense_sel_port_a_f = ext_sense_ctrl[4:3];
    wire        polarity_port_a    = ext_sense_ctrl[2];
    wire        top_pin_edge_sel   = ext_sense_ctrl[1];
    wire        top_pin_irq_on     = ext_sense_ctrl[0];
    // The timebase source has no port yet, so its vector never pends here.
    wire        timebase_irq       = 1'b0;
    wire        periph_irq_tb      = (periph_irq[5] & 1'b0) | timebase_irq;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign branch_if_masked   = at_lvl3;
    assign branch_if_unmasked = ~at_lvl3;

    // pair code to numeric level, 3 highest.
    function [2:0] lvl_num;
        input [1:0] code;
        begin
            case (code)
                `NIRQ_LVL0: lvl_num = 3'd0;
                `NIRQ_LVL1: lvl_num = 3'd1;
                `NIRQ_LVL2: lvl_num = 3'd2;
                default:    lvl_num = 3'd3;
            endcase
        end
    endfunction

    // pair of vector x sits at bits 2x mod 8 of register x/4.
    function [1:0] vec_prio;
        input [3:0] x;
        reg   [7:0] r;
        begin
            r = prio_reg[x[3:2]];
            vec_prio = r[{x[1:0], 1'b0} +: 2];
        end
    endfunction

    // a pair written with level 0 keeps its old value.
    function [7:0] merge_prio;
        input [7:0] old;
        input [7:0] wr;
        integer     k;
        begin
            merge_prio = wr;
            for (k = 0; k < 4; k = k + 1)
            begin
                if (wr[2*k +: 2] == `NIRQ_LVL0)
                    merge_prio[2*k +: 2] = old[2*k +: 2];
            end
        end
    endfunction

    // event for one line, given sample, previous, sense and inversion.
    function detect;
        input       now;
        input       prev;
        input [1:0] sel;
        input       inv;
        reg         rise;
        reg         fall;
        begin
            rise = now & ~prev;
            fall = ~now & prev;
            case (sel)
                `NIRQ_SENS_FALL_LOW: detect = inv ? (rise | now) : (fall | ~now);
                `NIRQ_SENS_RISE:     detect = inv ? fall : rise;
                `NIRQ_SENS_FALL:     detect = inv ? rise : fall;
                default:             detect = rise | fall;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pins sharing one line are ORed before the synchroniser, so a glitch
    // between two pins of a group may be seen as one edge.
    wire [3:0] line_raw = {|port_b_pins[7:4], |port_b_pins[3:0],
                           |port_f_pins, |port_a_pins};

    // two-stage synchronisers
    // They reset to the idle-high pin level, so a low-level sense does not
    // see a false event while the stages fill after reset.
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            line_s1   <= 4'hF;
            line_s2   <= 4'hF;
            line_prev <= 4'hF;
            top_s     <= 2'b11;
            top_prev  <= 1'b1;
        end
        else
        begin
            line_s1   <= line_raw;
            line_s2   <= line_s1;
            line_prev <= line_s2;
            top_s     <= {top_s[0], top_pin};
            top_prev  <= top_s[1];
        end
    end

    always @*
    begin
        // low field with port A polarity on line 0
        line_hit[0] = detect(line_s2[0], line_prev[0], sense_sel_port_a_f, polarity_port_a);
        line_hit[1] = detect(line_s2[1], line_prev[1], sense_sel_port_a_f, 1'b0);
        // line 2 follows the polarity column, line 3 does not.
        line_hit[2] = detect(line_s2[2], line_prev[2], sense_sel_port_b, polarity_port_b);
        line_hit[3] = detect(line_s2[3], line_prev[3], sense_sel_port_b, 1'b0);
    end

    wire top_edge = top_pin_irq_on &
                    (top_pin_edge_sel ? (top_s[1] & ~top_prev) : (~top_s[1] & top_prev));

    wire ctrl_sel = bus_wr && (paddr == `NIRQ_SENSE_ADDR);
    // sense and polarity fields need level 3.
    wire [7:0] lock_mask = at_lvl3 ? 8'hFC : 8'h00;
    // edge select frozen while the pin interrupt is on.
    wire [7:0] top_pin_edge_sel_mask = top_pin_irq_on ? 8'h00 : 8'h02;
    wire [7:0] wr_mask   = lock_mask | top_pin_edge_sel_mask | 8'h01;
    wire [7:0] next_ctrl = (pwdata[7:0] & wr_mask) | (ext_sense_ctrl & ~wr_mask);
    // any change to sense or polarity drops pending lines.
    wire sense_changed = ctrl_sel && ((next_ctrl[7:2] ^ ext_sense_ctrl[7:2]) != 6'h00);

    ////////////////////////////////////////////////////////////////////////////
    // priority registers, sense register
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            prio_reg[0]    <= `NIRQ_PRIO_RESET;
            prio_reg[1]    <= `NIRQ_PRIO_RESET;
            prio_reg[2]    <= `NIRQ_PRIO_RESET;
            prio_reg[3]    <= `NIRQ_PRIO_RESET;
            ext_sense_ctrl <= `NIRQ_SENSE_RESET;
        end
        else if (bus_wr)
        begin
            case (paddr)
                `NIRQ_PRIO0_ADDR: prio_reg[0] <= merge_prio(prio_reg[0], pwdata[7:0]);
                `NIRQ_PRIO1_ADDR: prio_reg[1] <= merge_prio(prio_reg[1], pwdata[7:0]);
                `NIRQ_PRIO2_ADDR: prio_reg[2] <= merge_prio(prio_reg[2], pwdata[7:0]);
                `NIRQ_PRIO3_ADDR: prio_reg[3] <= merge_prio(prio_reg[3], pwdata[7:0])
                                                 | `NIRQ_PRIO3_RO_MASK;
                `NIRQ_SENSE_ADDR: ext_sense_ctrl <= next_ctrl;
                default:          ext_sense_ctrl <= ext_sense_ctrl;
            endcase
        end
    end

    always @(posedge core_clk)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
        begin
            case (paddr)
                `NIRQ_PRIO0_ADDR:  prdata <= {24'h000000, prio_reg[0]};
                `NIRQ_PRIO1_ADDR:  prdata <= {24'h000000, prio_reg[1]};
                `NIRQ_PRIO2_ADDR:  prdata <= {24'h000000, prio_reg[2]};
                `NIRQ_PRIO3_ADDR:  prdata <= {24'h000000, prio_reg[3]};
                `NIRQ_SENSE_ADDR:  prdata <= {24'h000000, ext_sense_ctrl};
                `NIRQ_STATUS_ADDR: prdata <= {14'h0000, cur_prio, 2'b00, pending};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // halt-exit capability per source
    always @*
    begin
        wake_ok        = 14'h003F;
        wake_ok[6]     = 1'b1;
        wake_ok[`NIRQ_SRC_SPI] = spi_slave_mode;
        wake_ok[`NIRQ_SRC_PWM] = pwm_ext_clk;
        // active-halt is left only by the timebase vector.
        if (active_halt)
            wake_ok = 14'h0002;
    end

    // scan from source 13 down to 0 keeps the fixed hardware order on ties, so the lowest source wins.
    always @*
    begin
        next_src   = 4'd0;
        next_found = 1'b0;
        next_lvl   = 3'd0;
        for (i = `NIRQ_NUM_SRC - 1; i >= 0; i = i - 1)
        begin
            if (pending[i] && (!halted || wake_ok[i]))
            begin
                // the pin vector always ranks above any stored pair.
                if (i == 0)
                begin
                    next_src   = 4'd0;
                    next_found = 1'b1;
                    next_lvl   = 3'd4;
                end
                else if ((lvl_num(vec_prio(i[3:0])) >= next_lvl) || !next_found)
                begin
                    next_src   = i[3:0];
                    next_found = 1'b1;
                    next_lvl   = lvl_num(vec_prio(i[3:0]));
                end
            end
        end
    end

    // only a strictly higher level preempts, including the routine itself; the pin vector is taken at any level.
    wire take = next_found &&
                ((next_src == 4'd0) || (next_lvl > lvl_num(cur_prio)));

    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            irq_req    <= 1'b0;
            irq_vector <= `NIRQ_VEC_RESET;
            wake_req   <= 1'b0;
        end
        else
        begin
            irq_req    <= take;
            irq_vector <= `NIRQ_VEC_SRC0 - {11'h000, next_src, 1'b0};
            wake_req   <= halted & next_found;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latch events; a new event wins over the clear at acknowledge.
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pending    <= 14'h0000;
            in_service <= 14'h0000;
        end
        else
        begin
            if (irq_ack && irq_req)
            begin
                pending[next_src]    <= 1'b0;
                in_service[next_src] <= 1'b1;
            end
            if (return_from_irq)
                in_service <= 14'h0000;
            if (sense_changed)
                pending[5:2] <= 4'h0;
            for (j = 0; j < 4; j = j + 1)
            begin
                if (line_hit[j])
                    pending[j + 2] <= 1'b1;
            end
            if (top_edge)
                pending[0] <= 1'b1;
            pending[1] <= pending[1] | periph_irq_tb;
            for (j = 6; j < 14; j = j + 1)
            begin
                if (periph_irq[j])
                    pending[j] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Current priority bits of the flags register.
    always @(posedge core_clk)
    begin
        if (sys_rst)
            cur_prio <= `NIRQ_LVL3;
        // reset, trap and mask load level 3.
        else if (reset_vector_fetch || trap_instr || irq_mask_instr)
            cur_prio <= `NIRQ_LVL3;
        else if (irq_ack && irq_req)
            cur_prio <= (next_src == 4'd0) ? `NIRQ_LVL3 : vec_prio(next_src);
        else if (return_from_irq || pop_flags_instr)
            cur_prio <= stacked_prio;
        // halt, wait, unmask load 10. holds until next change.
        else if (halt_instr || wait_for_irq_instr || irq_unmask_instr)
            cur_prio <= `NIRQ_LVL0;
    end

endmodule // nirq_ctrl

// *** logic/nirq_defines.vh ***
`ifndef NIRQ_DEFINES_VH
`define NIRQ_DEFINES_VH
`define NIRQ_PRIO0_ADDR       12'h000
`define NIRQ_PRIO1_ADDR       12'h004
`define NIRQ_PRIO2_ADDR       12'h008
`define NIRQ_PRIO3_ADDR       12'h00C
`define NIRQ_SENSE_ADDR       12'h010
`define NIRQ_STATUS_ADDR      12'h014
`define NIRQ_PRIO_RESET       8'hFF
`define NIRQ_SENSE_RESET      8'h00
`define NIRQ_PRIO3_RO_MASK    8'hF0
`define NIRQ_LVL0             2'b10
`define NIRQ_LVL1             2'b01
`define NIRQ_LVL2             2'b00
`define NIRQ_LVL3             2'b11
`define NIRQ_SENS_FALL_LOW    2'b00
`define NIRQ_SENS_RISE        2'b01
`define NIRQ_SENS_FALL        2'b10
`define NIRQ_SENS_BOTH        2'b11
`define NIRQ_VEC_RESET        16'hFFFE
`define NIRQ_VEC_TRAP         16'hFFFC
`define NIRQ_VEC_SRC0         16'hFFFA
`define NIRQ_NUM_SRC          14
`define NIRQ_SRC_TIMEBASE     1
`define NIRQ_SRC_SPI          7
`define NIRQ_SRC_PWM          13
`endif
